// ==== core/quad_timer.sv ====
// Purpose: four counter/timers with register port and event pins
// Assumes: pins are asynchronous; register port is on clk_sys
// Notes:   gate inputs are active high; invert outside if needed
`include "quad_timer_map.svh"

module quad_timer (
  // clock and reset
  input  wire logic       clk_sys,
  input  wire logic       rst_b,
  // register port
  input  wire logic [4:0] regAddr,
  input  wire logic [7:0] regWrData,
  input  wire logic       regWrite,
  input  wire logic       regRead,
  output logic      [7:0] regRdData,
  // event, gate and clock pins
  input  wire logic       timer0EventPin,
  input  wire logic       timer1EventPin,
  input  wire logic       extGateInputZero,
  input  wire logic       extGateInputOne,
  input  wire logic       extOscClk,
  input  wire logic       rtcOscClk,
  input  wire logic       cmpOut0,
  input  wire logic       cmpOut1,
  // overflow and capture requests towards the core
  output logic      [3:0] timerIrq
);

  // reset release chain
  logic [1:0] rstSync_ff;
  logic       rstN;

  // pin synchronisers and filtered levels
  logic [7:0] pinVec;
  logic [7:0] sync1_ff, sync2_ff, sync3_ff;
  logic [7:0] lvl_ff, nxt_lvl;
  logic [7:0] fallEv, riseEv;

  // dividers
  logic [5:0] div12_ff, nxt_div12;
  logic [5:0] div4_ff,  nxt_div4;
  logic [5:0] div48_ff, nxt_div48;
  logic [2:0] ext8_ff,  nxt_ext8;
  logic [2:0] rtc8_ff,  nxt_rtc8;
  logic       tick12, tick4, tick48, ext8Tick, rtc8Tick, preTick;

  // configuration registers
  logic [7:0] clkSel_ff, nxt_clkSel;
  logic [2:0] run_ff,    nxt_run;
  logic [7:0] tmode_ff,  nxt_tmode;
  logic [3:0] ien_ff,    nxt_ien;
  quad_timer_pkg::t23_cfg_t ctl23_ff [2];
  quad_timer_pkg::t23_cfg_t nxt_ctl23 [2];

  // counters and status
  logic [7:0]  tl_ff [2];
  logic [7:0]  th_ff [2];
  logic [7:0]  nxt_tl [2];
  logic [7:0]  nxt_th [2];
  logic [15:0] cnt_ff [2];
  logic [15:0] rl_ff [2];
  logic [15:0] nxt_cnt [2];
  logic [15:0] nxt_rl [2];
  logic [3:0]  flag_ff, nxt_flag, ovfSet;
  logic [3:0]  irq_ff;
  logic [7:0]  rd_ff, nxt_rd;

  // release reset two edges after rst_b rises
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      rstSync_ff <= 2'h0;
    end else begin
      rstSync_ff <= {rstSync_ff[0], 1'h1};
    end
  end
  assign rstN = rstSync_ff[1];

  assign pinVec = {cmpOut1, cmpOut0, rtcOscClk, extOscClk,
                   extGateInputOne, extGateInputZero,
                   timer1EventPin, timer0EventPin};

  // level only moves once stages two and three agree; stage one
  // feeds stage two alone so a metastable value never fans out
  always_comb begin
    for (int p = 0; p < 8; p++) begin
      nxt_lvl[p] = (sync2_ff[p] == sync3_ff[p]) ? sync3_ff[p]
                                                : lvl_ff[p]; // R19
      fallEv[p]  = lvl_ff[p] & ~nxt_lvl[p];  // R11
      riseEv[p]  = ~lvl_ff[p] & nxt_lvl[p];
    end
  end

  // synchroniser flops; high levels need two stable clocks
  always_ff @(posedge clk_sys or negedge rstN) begin
    if (!rstN) begin
      sync1_ff <= 8'hFF;
      sync2_ff <= 8'hFF;
      sync3_ff <= 8'hFF;
      lvl_ff   <= 8'hFF;
    end else begin
      sync1_ff <= pinVec;
      sync2_ff <= sync1_ff;
      sync3_ff <= sync2_ff;
      lvl_ff   <= nxt_lvl;  // R12 R13
    end
  end

  // prescale dividers; each tick is a one-cycle enable
  always_comb begin
    tick12    = (div12_ff == `QT_DIV12_END);
    tick4     = (div4_ff  == `QT_DIV4_END);
    tick48    = (div48_ff == `QT_DIV48_END);
    ext8Tick  = riseEv[`QT_PIN_EXT] & (ext8_ff == `QT_DIV8_END);
    rtc8Tick  = riseEv[`QT_PIN_RTC] & (rtc8_ff == `QT_DIV8_END);
    nxt_div12 = tick12 ? 6'h00 : div12_ff + 6'h01;
    nxt_div4  = tick4  ? 6'h00 : div4_ff  + 6'h01;
    nxt_div48 = tick48 ? 6'h00 : div48_ff + 6'h01;
    nxt_ext8  = ext8_ff + {2'h0, riseEv[`QT_PIN_EXT]};
    nxt_rtc8  = rtc8_ff + {2'h0, riseEv[`QT_PIN_RTC]};
    case (clkSel_ff[1:0])  // R15
      2'h0:    preTick = tick12;
      2'h1:    preTick = tick4;
      2'h2:    preTick = tick48;
      default: preTick = ext8Tick;
    endcase
  end

  // divider registers
  always_ff @(posedge clk_sys or negedge rstN) begin
    if (!rstN) begin
      div12_ff <= 6'h00;
      div4_ff  <= 6'h00;
      div48_ff <= 6'h00;
      ext8_ff  <= 3'h0;
      rtc8_ff  <= 3'h0;
    end else begin
      div12_ff <= nxt_div12;
      div4_ff  <= nxt_div4;
      div48_ff <= nxt_div48;
      ext8_ff  <= nxt_ext8;
      rtc8_ff  <= nxt_rtc8;
    end
  end

  // timers 0 and 1; software writes to count bytes win over counting
  always_comb begin
    quad_timer_pkg::t01_cfg_t cfg;
    logic       tmrTick, inc, en;
    logic [12:0] c13;
    logic [15:0] c16;
    cfg = '0;
    tmrTick = 1'h0;
    inc = 1'h0;
    en = 1'h0;
    c13 = 13'h0000;
    c16 = 16'h0000;
    ovfSet = 4'h0;
    for (int i = 0; i < 2; i++) begin
      nxt_tl[i] = tl_ff[i];
      nxt_th[i] = th_ff[i];
      cfg = quad_timer_pkg::t01_cfg_t'(tmode_ff[i*4 +: 4]);
      // select bit chooses system clock or prescaled tick
      tmrTick = clkSel_ff[`QT_T0M + i] ? 1'h1 : preTick;  // R6 R7
      en = run_ff[i] & (~cfg.gateEn
                        | lvl_ff[`QT_PIN_TIMER0_GATE_ENABLE + i]);  // R17
      inc = (cfg.cntSel ? fallEv[`QT_PIN_EV0 + i]
                        : tmrTick) & en;  // R11 R16
      c13 = {th_ff[i], tl_ff[i][4:0]};
      c16 = {th_ff[i], tl_ff[i]};
      case (cfg.mode)  // R2
        quad_timer_pkg::MODE_13BIT: begin
          if (inc) begin
            c13 = c13 + 13'h0001;
            nxt_th[i] = c13[12:5];
            nxt_tl[i] = {tl_ff[i][7:5], c13[4:0]};
            // or in: timer 0 split may already have raised flag 1
            ovfSet[i] = ovfSet[i] | (c13 == 13'h0000);  // R20
          end
        end
        quad_timer_pkg::MODE_16BIT: begin
          if (inc) begin
            c16 = c16 + 16'h0001;
            {nxt_th[i], nxt_tl[i]} = c16;
            ovfSet[i] = ovfSet[i] | (c16 == 16'h0000);  // R20
          end
        end
        quad_timer_pkg::MODE_8BIT_RELOAD: begin
          if (inc) begin
            // reload byte itself is left untouched
            nxt_tl[i] = (tl_ff[i] == 8'hFF) ? th_ff[i]
                                             : tl_ff[i] + 8'h01;
            ovfSet[i] = ovfSet[i] | (tl_ff[i] == 8'hFF);  // R20
          end
        end
        default: begin
          // split: timer 0 only, high byte borrows timer 1 flag;
          // timer 1 holds its count in this mode
          if (i == 0) begin  // R3
            if (inc) begin
              nxt_tl[0] = tl_ff[0] + 8'h01;
              ovfSet[0] = (tl_ff[0] == 8'hFF);
            end
            if (tmrTick & run_ff[`QT_RUN0HI]) begin
              nxt_th[0] = th_ff[0] + 8'h01;
              ovfSet[1] = (th_ff[0] == 8'hFF);
            end
          end
        end
      endcase
      if (regWrite && regAddr == `QT_TL0 + 5'(2*i)) begin
        nxt_tl[i] = regWrData;
      end
      if (regWrite && regAddr == `QT_TH0 + 5'(2*i)) begin
        nxt_th[i] = regWrData;
      end
    end
    // timers 2 and 3 share one description via the loop
    for (int j = 0; j < 2; j++) begin
      logic        lowTick, highTick, altTick, capEvt;
      logic [4:0]  base;
      altTick = 1'h0;
      base = `QT_T23_BASE + 5'(j) * `QT_T23_STRIDE;
      nxt_cnt[j] = cnt_ff[j];
      nxt_rl[j] = rl_ff[j];
      case (ctl23_ff[j].altSel)  // R8 R9 R10
        2'h1:    altTick = (j == 0) ? rtc8Tick : ext8Tick;
        2'h2:    altTick = riseEv[`QT_PIN_CMP0 + j];
        default: altTick = tick12;
      endcase
      lowTick  = clkSel_ff[`QT_TIMER2_LOW_CLOCK_SELECT + 2*j] ? 1'h1 : altTick;  // R18
      highTick = clkSel_ff[`QT_T2MH + 2*j] ? 1'h1 : altTick;
      capEvt   = (ctl23_ff[j].altSel == 2'h1) ? altTick
                                              : riseEv[`QT_PIN_CMP0 + j];
      if (ctl23_ff[j].run) begin
        if (ctl23_ff[j].capEn) begin
          // free count on system clock or /12, latch on source edge
          if (clkSel_ff[`QT_TIMER2_LOW_CLOCK_SELECT + 2*j] | tick12) begin
            nxt_cnt[j] = cnt_ff[j] + 16'h0001;
          end
          if (capEvt) begin  // R5
            nxt_rl[j] = cnt_ff[j];
            ovfSet[2+j] = 1'h1;
          end
        end else if (ctl23_ff[j].split) begin  // R4
          if (lowTick) begin
            nxt_cnt[j][7:0] = (cnt_ff[j][7:0] == 8'hFF)
                            ? rl_ff[j][7:0] : cnt_ff[j][7:0] + 8'h01;
          end
          if (highTick) begin
            nxt_cnt[j][15:8] = (cnt_ff[j][15:8] == 8'hFF)
                             ? rl_ff[j][15:8] : cnt_ff[j][15:8] + 8'h01;
            ovfSet[2+j] = (cnt_ff[j][15:8] == 8'hFF);  // R20
          end
        end else if (lowTick) begin  // R1 R4
          nxt_cnt[j] = (cnt_ff[j] == 16'hFFFF) ? rl_ff[j]
                                               : cnt_ff[j] + 16'h0001;
          ovfSet[2+j] = (cnt_ff[j] == 16'hFFFF);  // R20
        end
      end
      if (regWrite) begin
        case (regAddr - base)
          `QT_T23_CNTL: nxt_cnt[j][7:0]  = regWrData;
          `QT_T23_CNTH: nxt_cnt[j][15:8] = regWrData;
          `QT_T23_RLL:  nxt_rl[j][7:0]   = regWrData;
          `QT_T23_RLH:  nxt_rl[j][15:8]  = regWrData;
          default:      nxt_cnt[j] = nxt_cnt[j];
        endcase
      end
    end
  end

  // control writes, flags and read data
  always_comb begin
    nxt_clkSel = clkSel_ff;
    nxt_run    = run_ff;
    nxt_tmode  = tmode_ff;
    nxt_ien    = ien_ff;
    nxt_ctl23  = ctl23_ff;
    nxt_flag   = flag_ff;
    nxt_rd     = 8'h00;
    if (regWrite) begin
      case (regAddr)
        `QT_CLKSEL: nxt_clkSel = regWrData;
        `QT_TMODE:  nxt_tmode  = regWrData;
        `QT_IEN:    nxt_ien    = regWrData[3:0];
        `QT_TCTL: begin
          // setting a run bit never clears the count
          nxt_run  = regWrData[2:0];  // R17
          // writing zero clears a flag, writing one leaves it
          nxt_flag = flag_ff & regWrData[`QT_FLAG_LSB +: 4];
        end
        `QT_T23_BASE:
          nxt_ctl23[0] = quad_timer_pkg::t23_cfg_t'(regWrData);
        `QT_T23_BASE + `QT_T23_STRIDE:
          nxt_ctl23[1] = quad_timer_pkg::t23_cfg_t'(regWrData);
        default: nxt_run = run_ff;
      endcase
    end
    // a wrap in the clearing cycle still lands
    nxt_flag = nxt_flag | ovfSet;  // R20
    if (regRead) begin
      case (regAddr)
        `QT_CLKSEL: nxt_rd = clkSel_ff;
        `QT_TCTL:   nxt_rd = {flag_ff, 1'h0, run_ff};
        `QT_TMODE:  nxt_rd = tmode_ff;
        `QT_TL0:    nxt_rd = tl_ff[0];
        `QT_TH0:    nxt_rd = th_ff[0];
        `QT_TL1:    nxt_rd = tl_ff[1];
        `QT_TH1:    nxt_rd = th_ff[1];
        `QT_IEN:    nxt_rd = {4'h0, ien_ff};
        `QT_T23_BASE + `QT_T23_CTL:  nxt_rd = ctl23_ff[0];
        `QT_T23_BASE + `QT_T23_CNTL: nxt_rd = cnt_ff[0][7:0];
        `QT_T23_BASE + `QT_T23_CNTH: nxt_rd = cnt_ff[0][15:8];
        `QT_T23_BASE + `QT_T23_RLL:  nxt_rd = rl_ff[0][7:0];
        `QT_T23_BASE + `QT_T23_RLH:  nxt_rd = rl_ff[0][15:8];
        `QT_T23_BASE + `QT_T23_STRIDE + `QT_T23_CTL:
          nxt_rd = ctl23_ff[1];
        `QT_T23_BASE + `QT_T23_STRIDE + `QT_T23_CNTL:
          nxt_rd = cnt_ff[1][7:0];
        `QT_T23_BASE + `QT_T23_STRIDE + `QT_T23_CNTH:
          nxt_rd = cnt_ff[1][15:8];
        `QT_T23_BASE + `QT_T23_STRIDE + `QT_T23_RLL:
          nxt_rd = rl_ff[1][7:0];
        `QT_T23_BASE + `QT_T23_STRIDE + `QT_T23_RLH:
          nxt_rd = rl_ff[1][15:8];
        default:    nxt_rd = 8'h00;  // unmapped reads zero
      endcase
    end
  end

  // all register state
  always_ff @(posedge clk_sys or negedge rstN) begin
    if (!rstN) begin
      clkSel_ff <= 8'h00;
      run_ff    <= 3'h0;
      tmode_ff  <= 8'h00;
      ien_ff    <= 4'h0;
      flag_ff   <= 4'h0;
      irq_ff    <= 4'h0;
      rd_ff     <= 8'h00;
      for (int k = 0; k < 2; k++) begin
        ctl23_ff[k] <= '0;
        tl_ff[k]    <= 8'h00;
        th_ff[k]    <= 8'h00;
        cnt_ff[k]   <= 16'h0000;
        rl_ff[k]    <= 16'h0000;
      end
    end else begin
      clkSel_ff <= nxt_clkSel;
      run_ff    <= nxt_run;
      tmode_ff  <= nxt_tmode;
      ien_ff    <= nxt_ien;
      flag_ff   <= nxt_flag;
      irq_ff    <= nxt_flag & nxt_ien;  // R14 R20
      rd_ff     <= nxt_rd;
      ctl23_ff  <= nxt_ctl23;
      tl_ff     <= nxt_tl;
      th_ff     <= nxt_th;
      cnt_ff    <= nxt_cnt;
      rl_ff     <= nxt_rl;
    end
  end

  assign regRdData = rd_ff;
  assign timerIrq  = irq_ff;

endmodule

// ==== core/quad_timer_map.svh ====
// Purpose: register offsets, field positions and counts for quad_timer
// Assumes: 8-bit register port, 5-bit word address
// Notes:   offsets, field positions, pin indices and divider ends are named here
//
// Functional notes
// R1 - four 16-bit timers, two classic, two reload
// R2 - timers 0/1: 13-bit, 16-bit, 8-bit reload, split
// R3 - split mode exists on timer 0 only
// R4 - timers 2/3: 16-bit or two 8-bit reload
// R5 - timers 2/3 capture oscillator or comparator period
// R6 - timers 0/1 pick one of five sources
// R7 - each timer 0/1: prescaled or system clock
// R8 - timers 2/3: system clock or clock over 12
// R9 - timer 2 also: rtc over 8, comparator 0
// R10 - timer 3 also: ext osc over 8, comparator 1
// R11 - counter function counts falling pin edges
// R12 - events up to quarter system clock counted
// R13 - source holds each level two clocks minimum
// R14 - timers raise periodic interrupt requests
// R15 - prescale: /12, /4, /48, ext/8 synchronised
// R16 - select bit ignored in counter function
// R17 - run and gate enable counting; no clear
// R18 - low select 1 system, 0 alternate clock
// R19 - pins synchronised, one pulse per edge
// R20 - wrap sets flag, requests enabled interrupt
`ifndef QUAD_TIMER_MAP_SVH
`define QUAD_TIMER_MAP_SVH

// register offsets
`define QT_CLKSEL      5'h00
`define QT_TCTL        5'h01
`define QT_TMODE       5'h02
`define QT_TL0         5'h03
`define QT_TH0         5'h04
`define QT_TL1         5'h05
`define QT_TH1         5'h06
`define QT_T23_BASE    5'h07
`define QT_T23_STRIDE  5'h05
`define QT_T23_CTL     5'h00
`define QT_T23_CNTL    5'h01
`define QT_T23_CNTH    5'h02
`define QT_T23_RLL     5'h03
`define QT_T23_RLH     5'h04
`define QT_IEN         5'h11

// field positions
`define QT_RUN0        0
`define QT_RUN1        1
`define QT_RUN0HI      2
`define QT_FLAG_LSB    4
`define QT_T0M         2
`define QT_T1M         3
`define QT_TIMER2_LOW_CLOCK_SELECT        4
`define QT_T2MH        5

// pin indices in the synchroniser vector
`define QT_PIN_EV0     0
`define QT_PIN_TIMER0_GATE_ENABLE   2
`define QT_PIN_EXT     4
`define QT_PIN_RTC     5
`define QT_PIN_CMP0    6

// divider terminal counts
`define QT_DIV12_END   6'h0B
`define QT_DIV4_END    6'h03
`define QT_DIV48_END   6'h2F
`define QT_DIV8_END    3'h7

`endif

// ==== core/quad_timer_pkg.sv ====
// Purpose: types shared by the quad timer
// Assumes: nothing beyond SystemVerilog packages
// Notes:   offsets and counts live in quad_timer_map.svh
package quad_timer_pkg;

  // timer 0/1 operating modes
  typedef enum logic [1:0] {
    MODE_13BIT,
    MODE_16BIT,
    MODE_8BIT_RELOAD,
    MODE_SPLIT
  } t01_mode_t;

  // per-timer nibble of the mode register
  typedef struct packed {
    logic      gateEn;   // count only while gate pin high
    logic      cntSel;   // 1: count pin falling edges
    t01_mode_t mode;
  } t01_cfg_t;

  // timer 2/3 control register
  typedef struct packed {
    logic       spare;
    logic       capEn;   // capture mode
    logic [1:0] altSel;  // alternate clock source
    logic       split;   // two 8-bit timers
    logic [1:0] spare2;
    logic       run;
  } t23_cfg_t;

endpackage

// ==== tb/quad_timer_sva.sv ====
// Purpose: port checks for quad_timer
// Assumes: one clock domain, bound to the top module
// Notes:   copies hold what software last wrote
`include "quad_timer_map.svh"

module quad_timer_sva (
  // clock and reset
  input wire logic       clk_sys,
  input wire logic       rst_b,
  // register port
  input wire logic [4:0] regAddr,
  input wire logic [7:0] regWrData,
  input wire logic       regWrite,
  input wire logic       regRead,
  input wire logic [7:0] regRdData,
  // requests towards the core
  input wire logic [3:0] timerIrq
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_b);

  logic [7:0] modeCopy_ff;  // mode byte as written
  logic [7:0] cselCopy_ff;  // clock select as written
  logic [3:0] ienCopy_ff;   // enables as written

  // copies follow writes only, so a read can never disturb them
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      modeCopy_ff <= 8'h00;
      cselCopy_ff <= 8'h00;
      ienCopy_ff  <= 4'h0;
    end else if (regWrite) begin
      if (regAddr == `QT_TMODE) modeCopy_ff <= regWrData;
      if (regAddr == `QT_CLKSEL) cselCopy_ff <= regWrData;
      if (regAddr == `QT_IEN) ienCopy_ff <= regWrData[3:0];
    end
  end

  chk_rd_idle: assert property (!$past(regRead) |-> regRdData == 8'h00)
    else $error("read data outside its slot");
  chk_in_reset: assert property (disable iff (1'b0) !rst_b |->
    regRdData == 8'h00 && timerIrq == 4'h0)
    else $error("outputs active in reset");
  chk_irq_enable: assert property ((timerIrq & ~ienCopy_ff) == 4'h0)
    else $error("request while disabled");
  chk_ien_clear: assert property (regWrite && regAddr == `QT_IEN &&
    regWrData[3:0] == 4'h0 |-> ##2 timerIrq == 4'h0)
    else $error("request survives disable");
  chk_rd_unmapped: assert property (regRead && regAddr > `QT_IEN
    |=> regRdData == 8'h00)
    else $error("unmapped read not zero");
  chk_rd_mode: assert property (regRead && regAddr == `QT_TMODE
    |=> regRdData == $past(modeCopy_ff))
    else $error("mode readback wrong");
  chk_rd_clksel: assert property (regRead && regAddr == `QT_CLKSEL
    |=> regRdData == $past(cselCopy_ff))
    else $error("clock select readback wrong");
  chk_irq_hold: assert property (timerIrq[0] && !regWrite
    |=> timerIrq[0])
    else $error("request dropped on its own");

  cover property ($rose(timerIrq[0]));
  cover property (regRead && regAddr > `QT_IEN);
  cover property (regWrite && regAddr == `QT_IEN && regWrData == 8'h00);
endmodule

bind quad_timer quad_timer_sva u_quad_timer_sva (.clk_sys, .rst_b,
  .regAddr, .regWrData, .regWrite, .regRead, .regRdData, .timerIrq);

// ==== tb/quad_timer_pins.sv ====
// Purpose: pin-side model for quad_timer
// Assumes: clocked by the bench system clock
// Notes:   oscillators run free; event pins move on request
module quad_timer_pins (
  // clock
  input  wire logic clk_sys,
  // pins towards the timer
  output logic      timer0EventPin,
  output logic      timer1EventPin,
  output logic      extOscClk,
  output logic      rtcOscClk,
  output logic      cmpOut0,
  output logic      cmpOut1
);
  timeunit 1ns;
  timeprecision 1ps;
  int tick = 0;  // free running cycle count

  // idle pins rest high so the first fall is a real event
  initial begin
    timer0EventPin = 1'b1;
    timer1EventPin = 1'b1;
    extOscClk = 1'b0;
    rtcOscClk = 1'b0;
    cmpOut0 = 1'b0;
    cmpOut1 = 1'b0;
  end

  // periods of 6, 10 and 14 clocks; each level outlasts two clocks
  always @(posedge clk_sys) begin
    tick <= tick + 1;
    extOscClk <= (tick % 6) < 3;
    rtcOscClk <= (tick % 10) < 5;
    cmpOut0 <= (tick % 14) < 7;
    cmpOut1 <= (tick % 14) >= 7;
  end

  // n low pulses, each level held half clocks (two at the fastest)
  task automatic pulse(input int pin, input int n, input int half);
    repeat (n) begin
      @(posedge clk_sys);
      if (pin == 0) timer0EventPin <= 1'b0;
      else timer1EventPin <= 1'b0;
      repeat (half) @(posedge clk_sys);
      if (pin == 0) timer0EventPin <= 1'b1;
      else timer1EventPin <= 1'b1;
      repeat (half - 1) @(posedge clk_sys);
    end
  endtask
endmodule

// ==== tb/quad_timer_tb_top.sv ====
// Purpose: self-checking bench for quad_timer
// Assumes: quad_timer_pins drives events and oscillators
// Notes:   free clock counts are judged within a small window
`include "quad_timer_map.svh"

module quad_timer_tb_top;
  timeunit 1ns;
  timeprecision 1ps;

  logic clk_sys = 1'b0;         // 125 MHz
  logic rst_b = 1'b1;           // active low, pulled low at 1 ns
  logic [4:0] regAddr = 5'h00;  // register port
  logic [7:0] regWrData = 8'h00;
  logic regWrite = 1'b0;
  logic regRead = 1'b0;
  logic [7:0] regRdData;
  logic extGateInputZero = 1'b0;  // gates driven here
  logic extGateInputOne = 1'b1;
  logic timer0EventPin, timer1EventPin, extOscClk, rtcOscClk;
  logic cmpOut0, cmpOut1;
  logic [3:0] timerIrq;
  int n_mismatch = 0;
  int total_checks = 0;
  int cycles = 0;
  logic [15:0] seed, v, c;
  logic [7:0] b;

  always #4 clk_sys = ~clk_sys;

  quad_timer u_quad_timer (.clk_sys, .rst_b, .regAddr, .regWrData,
    .regWrite, .regRead, .regRdData, .timer0EventPin, .timer1EventPin,
    .extGateInputZero, .extGateInputOne, .extOscClk, .rtcOscClk,
    .cmpOut0, .cmpOut1, .timerIrq);
  quad_timer_pins u_quad_timer_pins (.clk_sys, .timer0EventPin,
    .timer1EventPin, .extOscClk, .rtcOscClk, .cmpOut0, .cmpOut1);

  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction

  task automatic final_report();
    if (n_mismatch == 0 && total_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("MISMATCH %0t got %h want %h", $time, got, exp);
    end
  endtask

  // window check for counts driven by free clocks
  task automatic near(input logic [15:0] got, input int exp, input int tol);
    total_checks++;
    if ($isunknown(got) || got + tol < exp || got > exp + tol) begin
      n_mismatch++;
      $display("MISMATCH %0t count %h near %0d", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    regAddr <= a;
    regWrData <= d;
    regWrite <= 1'b1;
    @(posedge clk_sys);
    regWrite <= 1'b0;
  endtask

  // data stand only in the cycle after the strobe
  task automatic rd(input logic [4:0] a, output logic [7:0] d);
    @(posedge clk_sys);
    regAddr <= a;
    regRead <= 1'b1;
    @(posedge clk_sys);
    regRead <= 1'b0;
    #1 d = regRdData;
  endtask

  task automatic rd16(input logic [4:0] a, output logic [15:0] d);
    rd(a, d[7:0]);
    rd(a + 5'h01, d[15:8]);
  endtask

  // clear a count, run it for 960 clocks, read it back
  task automatic measure(input logic [4:0] ctl, input logic [4:0] lo,
      input logic [7:0] on, output logic [15:0] c);
    wr(lo, 8'h00);
    wr(lo + 5'h01, 8'h00);
    wr(ctl, on);
    repeat (960) @(posedge clk_sys);
    wr(ctl, 8'h00);
    rd16(lo, c);
  endtask

  // ceiling well above the longest expected run
  always @(posedge clk_sys) begin
    cycles <= cycles + 1;
    if (cycles == 60000) begin
      n_mismatch++;
      final_report();
    end
  end

  initial begin
    logic [7:0] cs[6] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h04, 8'h04};
    int dv[6] = '{12, 4, 48, 48, 1, 0};
    logic [7:0] ac[5] = '{8'h01, 8'h01, 8'h31, 8'h11, 8'h21};
    int da[2][5] = '{'{1, 12, 12, 80, 14}, '{1, 12, 12, 48, 14}};
    // a real falling edge before the first clock fires the async reset
    #1 rst_b = 1'b0;
    seed = 16'hD607;
    repeat (16) @(posedge clk_sys);
    rst_b <= 1'b1;
    repeat (3) @(posedge clk_sys);
    // all places wake at zero, unmapped ones stay there
    for (int a = 0; a < 20; a++) begin
      rd(a[4:0], b);
      chk(b, 16'h0000);
    end
    // random configuration bytes read back as written
    for (int i = 0; i < 6; i++) begin
      seed = lfsr(seed);
      wr(`QT_CLKSEL, seed[7:0]);
      wr(`QT_TMODE, seed[15:8]);
      rd(`QT_CLKSEL, b);
      chk(b, seed[7:0]);
      rd(`QT_TMODE, b);
      chk(b, seed[15:8]);
    end
    wr(`QT_CLKSEL, 8'h00);
    // falling edges at the top rate wrap the 16-bit count
    for (int p = 0; p < 2; p++) begin
      wr(`QT_TMODE, p ? 8'h50 : 8'h05);
      wr(`QT_TL0 + 5'(2 * p), 8'hFC);
      wr(`QT_TH0 + 5'(2 * p), 8'hFF);
      wr(`QT_IEN, 8'(1 << p));
      wr(`QT_TCTL, 8'(1 << p));
      u_quad_timer_pins.pulse(p, 6, 2);
      repeat (8) @(posedge clk_sys);
      rd16(`QT_TL0 + 5'(2 * p), v);
      chk(v, (16'hFFFC + 6) & 16'hFFFF);
      rd(`QT_TCTL, b);
      chk(b, 8'((8'h11) << p));
      chk(timerIrq, 4'(1 << p));
      wr(`QT_TCTL, 8'(1 << p));
      repeat (2) @(negedge clk_sys);
      chk(timerIrq, 4'h0);
      wr(`QT_TCTL, 8'h00);
      wr(`QT_IEN, 8'h00);
    end
    // gate low blocks, gate high passes, run keeps the count
    wr(`QT_TMODE, 8'h0D);
    wr(`QT_TL0, 8'h10);
    wr(`QT_TH0, 8'h00);
    wr(`QT_TCTL, 8'h01);
    for (int g = 0; g < 3; g++) begin
      extGateInputZero <= (g == 1);
      if (g == 2) wr(`QT_TCTL, 8'h00);
      repeat (4) @(posedge clk_sys);
      u_quad_timer_pins.pulse(0, 4, 2);
      repeat (8) @(posedge clk_sys);
      rd16(`QT_TL0, v);
      chk(v, 16'h0014 - (g == 0 ? 4 : 0));
    end
    // 8-bit reload: FE, FF, wrap to 80, then 81
    wr(`QT_TMODE, 8'h06);
    wr(`QT_TL0, 8'hFE);
    wr(`QT_TH0, 8'h80);
    wr(`QT_TCTL, 8'h01);
    u_quad_timer_pins.pulse(0, 3, 2);
    repeat (8) @(posedge clk_sys);
    rd16(`QT_TL0, v);
    chk(v, 16'h8081);
    wr(`QT_TCTL, 8'h00);
    // 13-bit: 1FFE plus three falls wraps to 0001
    wr(`QT_TMODE, 8'h04);
    wr(`QT_TL0, 8'h1E);
    wr(`QT_TH0, 8'hFF);
    wr(`QT_TCTL, 8'h01);
    u_quad_timer_pins.pulse(0, 3, 2);
    repeat (8) @(posedge clk_sys);
    rd16(`QT_TL0, v);
    chk(v, 16'h0001);
    rd(`QT_TCTL, b);
    chk(b, 8'h11);
    wr(`QT_TCTL, 8'h00);
    // five timer 0 sources; last pass is counter function on idle pin
    for (int i = 0; i < 6; i++) begin
      wr(`QT_TMODE, i == 5 ? 8'h05 : 8'h01);
      wr(`QT_CLKSEL, cs[i]);
      measure(`QT_TCTL, `QT_TL0, 8'h01, v);
      near(v, dv[i] ? 961 / dv[i] : 0, dv[i] ? 2 : 0);
    end
    // split timer 0: two system ticks wrap both bytes; set beats clear
    wr(`QT_TMODE, 8'h03);
    wr(`QT_CLKSEL, 8'h04);
    wr(`QT_TL0, 8'hFE);
    wr(`QT_TH0, 8'hFE);
    wr(`QT_TCTL, 8'h05);
    wr(`QT_TCTL, 8'h00);
    rd16(`QT_TL0, v);
    chk(v, 16'h0000);
    rd(`QT_TCTL, b);
    chk(b, 8'h30);
    // timers 2 and 3: system, over 12, oscillator over 8, comparator
    for (int t = 0; t < 2; t++) begin
      for (int i = 0; i < 5; i++) begin
        wr(`QT_CLKSEL, i == 0 ? 8'(8'h10 << (2 * t)) : 8'h00);
        measure(`QT_T23_BASE + 5'(5 * t), `QT_T23_BASE + 5'(5 * t + 1),
          ac[i], v);
        near(v, 961 / da[t][i], 2);
      end
    end
    // capture: count on system clock, latched every rtc/8 tick
    wr(`QT_CLKSEL, 8'h10);
    measure(`QT_T23_BASE, `QT_T23_BASE + `QT_T23_CNTL, 8'h51, v);
    near(v, 961, 2);
    rd16(`QT_T23_BASE + `QT_T23_RLL, c);
    near(c, int'(v) - 40, 40);
    rd(`QT_TCTL, b);
    chk(b[6], 1'b1);
    // timer 2 split: both bytes wrap to their own reload bytes
    wr(`QT_TCTL, 8'h00);
    wr(`QT_CLKSEL, 8'h30);
    wr(`QT_T23_BASE + `QT_T23_RLL, 8'h20);
    wr(`QT_T23_BASE + `QT_T23_RLH, 8'h10);
    wr(`QT_T23_BASE + `QT_T23_CNTL, 8'hFE);
    wr(`QT_T23_BASE + `QT_T23_CNTH, 8'hFE);
    wr(`QT_T23_BASE, 8'h09);
    wr(`QT_T23_BASE, 8'h00);
    rd16(`QT_T23_BASE + `QT_T23_CNTL, v);
    chk(v, 16'h1020);
    rd(`QT_TCTL, b);
    chk(b, 8'h40);
    final_report();
  end
endmodule
